// *** hdl/gpio_ports.sv ***
// Ports 0 to 2: APB register file, latches, pads, wake-up gate and demod tap
// What this block does
// R1: Pull-up off on any pin set output
// R2: Port reads return synchronised pin level
// R3: OR/AND/XOR read pins, combine, write latch; port 2 has only OR and AND, with no XOR word
// R4: Floating open-drain one reads back zero
// R5: Port 0 direction set per nibble
// R6: Config bit D2 selects port 0 drive
// R7: Software sets nibble direction before output use
// R8: Reset and stop recovery make port 0 input
// R9: Port 0 pull-up option chosen per nibble
// R10: Config bit D1 selects port 1 drive
// R11: Reset and stop recovery make port 1 input
// R12: Reserved port 1 ignores writes, reads ones
// R13: Port 2 direction set per bit
// R14: One setting selects port 2 drive mode
// R15: Reset makes all port 2 bits input
// R16: One option enables all port 2 pull-ups
// R17: Port 2 AND and OR gates wake part
// R18: Port 2 bit 0 feeds demod edge detector
// R19: Latch holds value while pin is input
//
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module gpio_ports
   import gpio_pkg::*;
#(
   parameter int WIDTH = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic stop_recovery,
   input wire logic edge_demod_timer_mode,
   input wire logic [WIDTH-1:0] port0_pins_in,
   output logic [WIDTH-1:0] port0_pins_out,
   output logic [WIDTH-1:0] port0_pins_oe_n,
   output logic [WIDTH-1:0] port0_pullup_en,
   input wire logic [WIDTH-1:0] port1_pins_in,
   output logic [WIDTH-1:0] port1_pins_out,
   output logic [WIDTH-1:0] port1_pins_oe_n,
   output logic [WIDTH-1:0] port1_pullup_en,
   input wire logic [WIDTH-1:0] port2_pins_in,
   output logic [WIDTH-1:0] port2_pins_out,
   output logic [WIDTH-1:0] port2_pins_oe_n,
   output logic [WIDTH-1:0] port2_pullup_en,
   output logic wake_up,
   output logic demod_edge_in
);
   localparam int HALF = WIDTH / 2;

   logic [WIDTH-1:0] p0_lvl, p1_lvl, p2_lvl;
   logic [WIDTH-1:0] lat0_q, lat1_q, lat2_q, lat0_d, lat1_d, lat2_d;
   logic [2:0] dir01_q, dir01_d;
   logic [WIDTH-1:0] dir2_q, dir2_d;
   logic [2:0] cfg_q, cfg_d;
   logic [5:0] opt_q, opt_d;
   logic [31:0] rdata_q, rdata_d;
   logic ready_q, ready_d, err_q, err_d;
   logic wake_q, wake_d, demod_q, demod_d;
   logic [WIDTH-1:0] p0_is_out, p1_is_out, p2_is_out;
   logic [WIDTH-1:0] p0_pu_opt, p1_pu_opt, p2_pu_opt;
   logic setup, wr, rd, rmw_hit, mapped;
   logic [1:0] rmw_port;
   rmw_op_t rmw_op;

   // Combine pin levels with an operand as the read-modify-write instructions do
   function automatic logic [WIDTH-1:0] rmw_apply(input rmw_op_t op,
         input logic [WIDTH-1:0] pins, input logic [WIDTH-1:0] opnd);
      logic [WIDTH-1:0] r;
      r = pins;
      unique case (op)
         RMW_OR: r = pins | opnd;
         RMW_AND: r = pins & opnd;
         RMW_XOR: r = pins ^ opnd;
         RMW_NONE: r = pins;
      endcase
      return r;
   endfunction

   pin_sync #(.WIDTH(WIDTH)) u_sync0 (
      .pclk(pclk),
      .presetn(presetn),
      .pin_in(port0_pins_in),
      .level(p0_lvl)
   );

   pin_sync #(.WIDTH(WIDTH)) u_sync1 (
      .pclk(pclk),
      .presetn(presetn),
      .pin_in(port1_pins_in),
      .level(p1_lvl)
   );

   pin_sync #(.WIDTH(WIDTH)) u_sync2 (
      .pclk(pclk),
      .presetn(presetn),
      .pin_in(port2_pins_in),
      .level(p2_lvl)
   );

   // Direction decode: direction register bits are 1 for input
   always_comb begin
      p0_is_out = {{HALF{~dir01_q[P0_HI_DIR_BIT]}}, {HALF{~dir01_q[P0_LO_DIR_BIT]}}}; // R5
      p1_is_out = opt_q[OPT_P1_RESERVED_BIT] ? '0 : {WIDTH{~dir01_q[P1_DIR_BIT]}};
      p2_is_out = ~dir2_q; // R13
      p0_pu_opt = {{HALF{opt_q[OPT_P0_HI_PULLUP_BIT]}},
                   {HALF{opt_q[OPT_P0_LO_PULLUP_BIT]}}}; // R9
      p1_pu_opt = '0;
      p2_pu_opt = {WIDTH{opt_q[OPT_P2_PULLUP_BIT]}}; // R16
   end

   port_driver #(.WIDTH(WIDTH)) u_drv0 (
      .pclk(pclk),
      .presetn(presetn),
      .latch(lat0_q),
      .is_output(p0_is_out),
      .push_pull(cfg_q[P0_PUSHPULL_BIT]), // R6
      .pullup_opt(p0_pu_opt),
      .pin_out(port0_pins_out),
      .pin_oe_n(port0_pins_oe_n),
      .pullup_en(port0_pullup_en)
   );

   port_driver #(.WIDTH(WIDTH)) u_drv1 (
      .pclk(pclk),
      .presetn(presetn),
      .latch(lat1_q),
      .is_output(p1_is_out),
      .push_pull(cfg_q[P1_PUSHPULL_BIT]), // R10
      .pullup_opt(p1_pu_opt),
      .pin_out(port1_pins_out),
      .pin_oe_n(port1_pins_oe_n),
      .pullup_en(port1_pullup_en)
   );

   port_driver #(.WIDTH(WIDTH)) u_drv2 (
      .pclk(pclk),
      .presetn(presetn),
      .latch(lat2_q),
      .is_output(p2_is_out),
      .push_pull(cfg_q[P2_PUSHPULL_BIT]), // R14
      .pullup_opt(p2_pu_opt),
      .pin_out(port2_pins_out),
      .pin_oe_n(port2_pins_oe_n),
      .pullup_en(port2_pullup_en)
   );

   // Bus decode; read-modify-write window holds OR, AND and XOR for ports 0 and 1, only OR and AND for port 2
   always_comb begin
      setup = psel && !penable;
      // A write lands at the edge where the master samples pready high
      wr = psel && penable && pwrite && ready_q;
      rd = setup && !pwrite;
      rmw_hit = (paddr >= ADDR_RMW_BASE) && (paddr <= ADDR_RMW_LAST)
                && (paddr[1:0] == 2'b00);
      rmw_port = 2'd0;
      rmw_op = RMW_NONE;
      if (rmw_hit) begin
         rmw_port = 2'((paddr - ADDR_RMW_BASE) >> 4);
         unique case (paddr[3:2])
            2'd0: rmw_op = RMW_OR;
            2'd1: rmw_op = RMW_AND;
            2'd2: rmw_op = RMW_XOR;
            default: rmw_op = RMW_NONE;
         endcase
         if (rmw_op == RMW_NONE) begin
            rmw_hit = 1'b0;
         end
      end
      mapped = rmw_hit;
      unique case (paddr)
         ADDR_PORT0, ADDR_PORT1, ADDR_PORT2, ADDR_PORT01_DIR, ADDR_PORT2_DIR,
         ADDR_PORT_CONFIG, ADDR_OPTION, ADDR_WAKE_STATUS: mapped = 1'b1;
         default: ;
      endcase
   end

   // Register updates; latches keep their value whatever the direction
   always_comb begin
      lat0_d = lat0_q; // R19
      lat1_d = lat1_q;
      lat2_d = lat2_q;
      dir01_d = dir01_q;
      dir2_d = dir2_q;
      cfg_d = cfg_q;
      opt_d = opt_q;
      if (wr) begin
         unique case (paddr)
            ADDR_PORT0: lat0_d = pwdata[WIDTH-1:0];
            ADDR_PORT1: if (!opt_q[OPT_P1_RESERVED_BIT]) lat1_d = pwdata[WIDTH-1:0]; // R12
            ADDR_PORT2: lat2_d = pwdata[WIDTH-1:0];
            ADDR_PORT01_DIR: dir01_d = pwdata[2:0]; // R7
            ADDR_PORT2_DIR: dir2_d = pwdata[WIDTH-1:0];
            ADDR_PORT_CONFIG: cfg_d = pwdata[2:0];
            ADDR_OPTION: opt_d = pwdata[5:0];
            default: ;
         endcase
         if (rmw_hit) begin
            // Pins are read, not the latch, so a floating open-drain one stores zero
            unique case (rmw_port)
               2'd0: lat0_d = rmw_apply(rmw_op, p0_lvl, pwdata[WIDTH-1:0]); // R3 R4
               2'd1: if (!opt_q[OPT_P1_RESERVED_BIT])
                  lat1_d = rmw_apply(rmw_op, p1_lvl, pwdata[WIDTH-1:0]); // R3
               2'd2: lat2_d = rmw_apply(rmw_op, p2_lvl, pwdata[WIDTH-1:0]); // R3
               default: ;
            endcase
         end
      end
      if (stop_recovery) begin
         dir01_d[P0_LO_DIR_BIT] = 1'b1; // R8
         dir01_d[P0_HI_DIR_BIT] = 1'b1; // R8
         dir01_d[P1_DIR_BIT] = 1'b1; // R11
      end
   end

   // Read data, answer in the access cycle
   always_comb begin
      rdata_d = rdata_q;
      ready_d = setup;
      err_d = setup && !mapped;
      if (rd) begin
         rdata_d = '0;
         unique case (paddr)
            ADDR_PORT0: rdata_d[WIDTH-1:0] = p0_lvl; // R2
            ADDR_PORT1: rdata_d[WIDTH-1:0] =
               opt_q[OPT_P1_RESERVED_BIT] ? RESERVED_READ : p1_lvl; // R2 R12
            ADDR_PORT2: rdata_d[WIDTH-1:0] = p2_lvl; // R2
            ADDR_PORT01_DIR: rdata_d[2:0] = dir01_q;
            ADDR_PORT2_DIR: rdata_d[WIDTH-1:0] = dir2_q;
            ADDR_PORT_CONFIG: rdata_d[2:0] = cfg_q;
            ADDR_OPTION: rdata_d[5:0] = opt_q;
            ADDR_WAKE_STATUS: rdata_d[1:0] = {&p2_lvl, |p2_lvl};
            default: ;
         endcase
      end
   end

   // Wake-up gate and edge-detector tap
   always_comb begin
      wake_d = opt_q[OPT_WAKE_SEL_BIT] ? &p2_lvl : |p2_lvl; // R17
      demod_d = edge_demod_timer_mode && opt_q[OPT_DEMOD_SEL_BIT] && p2_lvl[0]; // R18
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lat0_q <= LATCH_RESET;
         lat1_q <= LATCH_RESET;
         lat2_q <= LATCH_RESET;
         dir01_q <= DIR01_RESET; // R8 R11
         dir2_q <= DIR2_RESET; // R15
         cfg_q <= CONFIG_RESET;
         opt_q <= OPTION_RESET;
         rdata_q <= '0;
         ready_q <= 1'b0;
         err_q <= 1'b0;
         wake_q <= 1'b0;
         demod_q <= 1'b0;
      end else begin
         lat0_q <= lat0_d;
         lat1_q <= lat1_d;
         lat2_q <= lat2_d;
         dir01_q <= dir01_d;
         dir2_q <= dir2_d;
         cfg_q <= cfg_d;
         opt_q <= opt_d;
         rdata_q <= rdata_d;
         ready_q <= ready_d;
         err_q <= err_d;
         wake_q <= wake_d;
         demod_q <= demod_d;
      end
   end

   assign prdata = rdata_q;
   assign pready = ready_q;
   assign pslverr = err_q;
   assign wake_up = wake_q;
   assign demod_edge_in = demod_q;
endmodule
`default_nettype wire

// *** hdl/gpio_pkg.sv ***
// Package with register map, field positions and reset values of the port block
package gpio_pkg;
   localparam logic [7:0] ADDR_PORT0 = 8'h00;
   localparam logic [7:0] ADDR_PORT1 = 8'h04;
   localparam logic [7:0] ADDR_PORT2 = 8'h08;
   localparam logic [7:0] ADDR_PORT01_DIR = 8'h0c;
   localparam logic [7:0] ADDR_PORT2_DIR = 8'h10;
   localparam logic [7:0] ADDR_PORT_CONFIG = 8'h14;
   localparam logic [7:0] ADDR_OPTION = 8'h18;
   localparam logic [7:0] ADDR_WAKE_STATUS = 8'h1c;
   localparam logic [7:0] ADDR_RMW_BASE = 8'h20;
   localparam logic [7:0] ADDR_RMW_LAST = 8'h44;
   // port01_direction_reg fields: 1 = input
   localparam int P0_LO_DIR_BIT = 0;
   localparam int P0_HI_DIR_BIT = 1;
   localparam int P1_DIR_BIT = 2;
   // port_config_reg fields: 1 = push-pull
   localparam int P2_PUSHPULL_BIT = 0;
   localparam int P1_PUSHPULL_BIT = 1;
   localparam int P0_PUSHPULL_BIT = 2;
   // option fields
   localparam int OPT_P0_LO_PULLUP_BIT = 0;
   localparam int OPT_P0_HI_PULLUP_BIT = 1;
   localparam int OPT_P2_PULLUP_BIT = 2;
   localparam int OPT_P1_RESERVED_BIT = 3;
   localparam int OPT_WAKE_SEL_BIT = 4;
   localparam int OPT_DEMOD_SEL_BIT = 5;
   localparam logic [2:0] DIR01_RESET = 3'h7;
   localparam logic [7:0] DIR2_RESET = 8'hff;
   localparam logic [2:0] CONFIG_RESET = 3'h0;
   localparam logic [5:0] OPTION_RESET = 6'h00;
   localparam logic [7:0] LATCH_RESET = 8'h00;
   localparam logic [7:0] RESERVED_READ = 8'hff;
   // Read-modify-write operations, selected by address word
   typedef enum logic [1:0] {RMW_OR, RMW_AND, RMW_XOR, RMW_NONE} rmw_op_t;
endpackage

// *** hdl/pin_sync.sv ***
// Three-stage pin synchroniser; a change is accepted when stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module pin_sync
   import gpio_pkg::*;
#(
   parameter int WIDTH = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] level
);
   logic [WIDTH-1:0] s1_q, s2_q, s3_q, level_q;
   logic [WIDTH-1:0] level_d;

   always_comb begin
      level_d = level_q;
      for (int i = 0; i < WIDTH; i++) begin
         if (s2_q[i] == s3_q[i]) begin
            level_d[i] = s3_q[i];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         level_q <= '0;
      end else begin
         s1_q <= pin_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         level_q <= level_d;
      end
   end

   assign level = level_q;
endmodule
`default_nettype wire

// *** hdl/port_driver.sv ***
// Per-port pad control: drive enables, open-drain and pull-up gating for eight pins
`timescale 1ns/100ps
`default_nettype none
module port_driver
   import gpio_pkg::*;
#(
   parameter int WIDTH = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [WIDTH-1:0] latch,
   input wire logic [WIDTH-1:0] is_output,
   input wire logic push_pull,
   input wire logic [WIDTH-1:0] pullup_opt,
   output logic [WIDTH-1:0] pin_out,
   output logic [WIDTH-1:0] pin_oe_n,
   output logic [WIDTH-1:0] pullup_en
);
   logic [WIDTH-1:0] out_q, oe_n_q, pu_q;
   logic [WIDTH-1:0] out_d, oe_n_d, pu_d;

   always_comb begin
      out_d = latch;
      // Open drain only pulls low; a one leaves the pin floating
      oe_n_d = ~(is_output & (push_pull ? {WIDTH{1'b1}} : ~latch)); // R4
      pu_d = pullup_opt & ~is_output; // R1
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_q <= '0;
         oe_n_q <= '1;
         pu_q <= '0;
      end else begin
         out_q <= out_d;
         oe_n_q <= oe_n_d;
         pu_q <= pu_d;
      end
   end

   assign pin_out = out_q;
   assign pin_oe_n = oe_n_q;
   assign pullup_en = pu_q;
endmodule
`default_nettype wire

// *** sim/gpio_ports_checker.sv ***
// Concurrent checks on the port block's bus answer and pad outputs
`timescale 1ns/100ps
`default_nettype none
module gpio_ports_checker
   import gpio_pkg::*;
#(
   parameter int WIDTH = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [7:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic stop_recovery,
   input wire logic edge_demod_timer_mode,
   input wire logic demod_edge_in,
   input wire logic [WIDTH-1:0] port0_pins_oe_n,
   input wire logic [WIDTH-1:0] port1_pins_oe_n,
   input wire logic [WIDTH-1:0] port2_pins_oe_n,
   input wire logic [WIDTH-1:0] port0_pullup_en,
   input wire logic [WIDTH-1:0] port1_pullup_en,
   input wire logic [WIDTH-1:0] port2_pullup_en
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   pull_off_a: assert property (((~port0_pins_oe_n & port0_pullup_en) |
      (~port1_pins_oe_n & port1_pullup_en) | (~port2_pins_oe_n & port2_pullup_en)) == '0)
      else $error("pull-up enabled at a driven pin");
   ready_next_a: assert property (psel && !penable |=> pready)
      else $error("no answer in the access cycle");
   ready_once_a: assert property (pready |=> !pready)
      else $error("ready held past one cycle");
   ready_idle_a: assert property (!psel |=> !pready)
      else $error("ready without a transfer");
   err_unmapped_a: assert property (psel && !penable && paddr > ADDR_RMW_LAST |=> pslverr)
      else $error("unmapped address accepted");
   err_mapped_a: assert property (psel && !penable && paddr <= ADDR_WAKE_STATUS &&
      paddr[1:0] == 2'h0 |=> !pslverr)
      else $error("mapped address refused");
   stop_input_a: assert property (stop_recovery [*2] |=>
      &port0_pins_oe_n && &port1_pins_oe_n)
      else $error("port 0 or 1 driving during stop recovery");
   demod_off_a: assert property (!edge_demod_timer_mode |=> !demod_edge_in)
      else $error("edge tap active outside its mode");
endmodule
`default_nettype wire

// *** sim/pin_board.sv ***
// Board model of eight port pins: pad drive, pull-ups and external drivers
`timescale 1ns/100ps
`default_nettype none
module pin_board (
   input wire logic [7:0] pin_out,
   input wire logic [7:0] pin_oe_n,
   input wire logic [7:0] pullup_en,
   input wire logic [7:0] ext_val,
   input wire logic [7:0] ext_en,
   output logic [7:0] pin_level
);
   // Pad wins over the board driver; an undriven pin without pull-up reads low
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (!pin_oe_n[i]) pin_level[i] = pin_out[i];
         else if (ext_en[i]) pin_level[i] = ext_val[i];
         else pin_level[i] = pullup_en[i];
      end
   end
endmodule
`default_nettype wire

// *** sim/gpio_ports_tb_top.sv ***
// Self-checking bench for the three-port block with a board model per port
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; \
   $display("[FAIL] %0t %h %h", $time, (a), (b)); end end
module gpio_ports_tb_top;
   typedef struct {logic w; logic [7:0] a, d, e;} row_t;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic stop = 1'b0;
   logic mode = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic [31:0] rdat;
   logic pready, pslverr, rerr, wake, dmd;
   logic [7:0] ev [3] = '{8'h00, 8'h00, 8'h00};
   logic [7:0] ee [3] = '{8'h00, 8'h00, 8'h00};
   logic [7:0] po [3];
   logic [7:0] poe [3];
   logic [7:0] ppu [3];
   logic [7:0] lvl [3];
   logic [7:0] opnd [3] = '{8'h03, 8'hf0, 8'hff};
   logic [7:0] rmw_exp [3] = '{8'h3f, 8'h30, 8'hc3};
   logic [7:0] wv [5] = '{8'h00, 8'h01, 8'h01, 8'hff, 8'hfe};
   logic [7:0] wo [5] = '{8'h20, 8'h20, 8'h10, 8'h30, 8'h30};
   logic [1:0] wx [5] = '{2'h0, 2'h3, 2'h0, 2'h3, 2'h0};
   int err_count = 0;
   int compares = 0;
   row_t rows [10] = '{'{1'b0, 8'h0c, 8'h00, 8'h07}, '{1'b0, 8'h10, 8'h00, 8'hff},
      '{1'b0, 8'h14, 8'h00, 8'h00}, '{1'b0, 8'h18, 8'h00, 8'h00},
      '{1'b1, 8'h14, 8'h07, 8'h00}, '{1'b0, 8'h14, 8'h00, 8'h07},
      '{1'b1, 8'h10, 8'ha5, 8'h00}, '{1'b0, 8'h10, 8'h00, 8'ha5},
      '{1'b1, 8'h10, 8'hff, 8'h00}, '{1'b0, 8'h24, 8'h00, 8'h00}};
   always #2.5 pclk = ~pclk;
   gpio_ports dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .stop_recovery(stop), .edge_demod_timer_mode(mode),
      .port0_pins_in(lvl[0]), .port0_pins_out(po[0]), .port0_pins_oe_n(poe[0]),
      .port0_pullup_en(ppu[0]), .port1_pins_in(lvl[1]), .port1_pins_out(po[1]),
      .port1_pins_oe_n(poe[1]), .port1_pullup_en(ppu[1]), .port2_pins_in(lvl[2]),
      .port2_pins_out(po[2]), .port2_pins_oe_n(poe[2]), .port2_pullup_en(ppu[2]),
      .wake_up(wake), .demod_edge_in(dmd));
   for (genvar g = 0; g < 3; g++) begin : brd
      pin_board u (.pin_out(po[g]), .pin_oe_n(poe[g]), .pullup_en(ppu[g]),
         .ext_val(ev[g]), .ext_en(ee[g]), .pin_level(lvl[g]));
   end
   task automatic wrap_up();
      if (err_count == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         err_count++;
         wrap_up();
      end
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Second edge lets a write that landed at the answer edge reach the pads
      @(posedge pclk);
      @(posedge pclk);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
   endtask
   initial begin
      tick(12);
      presetn <= 1'b1;
      tick(1);
      foreach (rows[i]) begin
         apb(rows[i].w, rows[i].a, rows[i].d);
         if (!rows[i].w) `CHK(rdat, {24'h0, rows[i].e})
      end
      // Port 0 latch, per-nibble direction and pull-ups
      ev[0] <= 8'h3c;
      ee[0] <= 8'hff;
      apb(1'b1, 8'h18, 8'h03);
      apb(1'b1, 8'h00, 8'ha5);
      tick(6);
      apb(1'b0, 8'h00, 8'h00);
      `CHK(rdat[7:0], 8'h3c)
      `CHK(po[0], 8'ha5)
      `CHK(ppu[0], 8'hff)
      apb(1'b1, 8'h0c, 8'h06);
      ee[0] <= 8'hf0;
      tick(6);
      `CHK(poe[0], 8'hf0)
      `CHK(ppu[0], 8'hf0)
      apb(1'b0, 8'h00, 8'h00);
      `CHK(rdat[7:0], 8'h35)
      apb(1'b1, 8'h0c, 8'h07);
      ee[0] <= 8'hff;
      tick(6);
      foreach (opnd[i]) begin
         apb(1'b1, 8'h20 + 8'(4 * i), opnd[i]);
         `CHK(po[0], rmw_exp[i])
      end
      // Floating open-drain one, then drive mode switch
      ee[0] <= 8'h00;
      apb(1'b1, 8'h14, 8'h03);
      apb(1'b1, 8'h00, 8'hff);
      apb(1'b1, 8'h0c, 8'h04);
      tick(6);
      apb(1'b0, 8'h00, 8'h00);
      `CHK(rdat[7:0], 8'h00)
      apb(1'b1, 8'h24, 8'hff);
      `CHK(po[0], 8'h00)
      apb(1'b1, 8'h00, 8'hf0);
      `CHK(poe[0], 8'hf0)
      apb(1'b1, 8'h14, 8'h07);
      `CHK(poe[0], 8'h00)
      // Stop recovery
      apb(1'b1, 8'h10, 8'h00);
      apb(1'b1, 8'h0c, 8'h00);
      stop <= 1'b1;
      tick(3);
      stop <= 1'b0;
      tick(1);
      `CHK({poe[0], poe[1]}, 16'hffff)
      apb(1'b0, 8'h0c, 8'h00);
      `CHK(rdat[7:0], 8'h07)
      apb(1'b0, 8'h10, 8'h00);
      `CHK(rdat[7:0], 8'h00)
      // Port 1 drive modes and reserved option
      apb(1'b1, 8'h0c, 8'h03);
      apb(1'b1, 8'h04, 8'h0f);
      `CHK(poe[1], 8'h00)
      apb(1'b1, 8'h14, 8'h05);
      `CHK(poe[1], 8'h0f)
      apb(1'b1, 8'h18, 8'h08);
      apb(1'b1, 8'h04, 8'h55);
      `CHK(po[1], 8'h0f)
      apb(1'b0, 8'h04, 8'h00);
      `CHK(rdat[7:0], 8'hff)
      // Port 2 per-bit direction, pull-ups and global drive mode
      apb(1'b1, 8'h18, 8'h04);
      apb(1'b1, 8'h10, 8'hff);
      `CHK(ppu[2], 8'hff)
      apb(1'b1, 8'h08, 8'h0f);
      apb(1'b1, 8'h10, 8'h5a);
      `CHK(poe[2], 8'h5a)
      `CHK(ppu[2], 8'h5a)
      apb(1'b1, 8'h14, 8'h04);
      `CHK(poe[2], 8'h5f)
      // Wake-up gates and edge tap
      ee[2] <= 8'hff;
      mode <= 1'b1;
      apb(1'b1, 8'h10, 8'hff);
      foreach (wv[i]) begin
         ev[2] <= wv[i];
         apb(1'b1, 8'h18, wo[i]);
         tick(6);
         `CHK({wake, dmd}, wx[i])
      end
      apb(1'b0, 8'h80, 8'h00);
      `CHK(rerr, 1'b1)
      wrap_up();
   end
endmodule
bind gpio_ports gpio_ports_checker #(.WIDTH(WIDTH)) chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
   .stop_recovery(stop_recovery), .edge_demod_timer_mode(edge_demod_timer_mode),
   .demod_edge_in(demod_edge_in), .port0_pins_oe_n(port0_pins_oe_n),
   .port1_pins_oe_n(port1_pins_oe_n), .port2_pins_oe_n(port2_pins_oe_n),
   .port0_pullup_en(port0_pullup_en), .port1_pullup_en(port1_pullup_en),
   .port2_pullup_en(port2_pullup_en));
`default_nettype wire
